/* dv/sarro_host.sv */
// Host model: bursts the shift clock once a result is ready, captures bits.
// Assumes a 30 ns shift clock, idle high between frames.
`timescale 1ns/1ps
`default_nettype none
module sarro_host (
   // Control
   input  wire logic   read_en,
   input  wire logic   echo_mode,
   input  wire logic   result_ready,
   // Link
   input  wire logic   serial_data,
   output logic        shift_clk,
   // Captured frame
   output logic [18:0] word,
   output logic        word_done
);
   initial begin
      shift_clk = 1'b1;
      word_done = 1'b0;
      word = 19'h0;
   end
   // burst after ready, exact count per mode
   always @(posedge result_ready) begin
      if (read_en) begin
         word = 19'h0;
         #7;
         for (int i = 0; i < (echo_mode ? 16 : 19); i++) begin
            shift_clk = 1'b0;
            #15;
            shift_clk = 1'b1;
            #2;
            // capture on the following rising edge
            word = {word[17:0], serial_data};
            #13;
         end
         word_done = ~word_done;
      end
   end
endmodule // sarro_host
`default_nettype wire

/* dv/sarro_top_assertions.sv */
// Checker on the readout top's ports.
// Assumes ref_clk and reset as on the top.
`timescale 1ns/1ps
`default_nettype none
module sarro_chk (
   // Core and link inputs
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic convert_strobe,
   input wire logic echo_mode,
   input wire logic shift_clk,
   // Outputs watched
   input wire logic serial_data,
   input wire logic echoed_shift_clock,
   input wire logic pos_array_ground_switch,
   input wire logic neg_array_ground_switch,
   input wire logic result_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence conv_start; $fell(pos_array_ground_switch); endsequence
   sequence ready_wait; ##1 (!result_ready)[*8] ##[17:24] $rose(result_ready); endsequence
   a_strobe_starts: assert property ($rose(convert_strobe) |-> ##[1:4] !pos_array_ground_switch)
      else $error("strobe started no conversion");
   a_switch_pair: assert property (pos_array_ground_switch == neg_array_ground_switch)
      else $error("ground switches differ");
   a_conv_span: assert property (conv_start |=> (!pos_array_ground_switch)[*8])
      else $error("conversion too short");
   a_ready_time: assert property (conv_start |-> ready_wait)
      else $error("ready at wrong time");
   a_ready_holds: assert property ($fell(result_ready) |-> $past(convert_strobe))
      else $error("ready dropped without strobe");
   a_echo_copy: assert property (echo_mode && $changed(shift_clk) |->
      echoed_shift_clock == shift_clk)
      else $error("echo clock differs");
   a_echo_off: assert property (!echo_mode && $changed(shift_clk) |=> !echoed_shift_clock)
      else $error("echo clock in self mode");
   a_data_fall: assert property ($changed(serial_data) |-> !shift_clk)
      else $error("data moved off falling edge");
endmodule // sarro_chk
bind sarro_top sarro_chk i_chk (.ref_clk, .reset, .convert_strobe, .echo_mode, .shift_clk,
   .serial_data, .echoed_shift_clock, .pos_array_ground_switch, .neg_array_ground_switch,
   .result_ready);
`default_nettype wire

/* dv/test_sar_adc_serial_readout.sv */
// Bench: conversions in both read modes, checked frame by frame.
// Assumes sarro_host as host and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CMP(w, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s exp %h got %h", w, e, s); end end
module test_sar_adc_serial_readout;
   logic        ref_clk = 1'b0, reset = 1'b1, convert_strobe = 1'b0, echo_mode = 1'b0;
   logic        read_en = 1'b1, shift_clk, serial_data, echoed_shift_clock, word_done;
   logic        pos_array_ground_switch, neg_array_ground_switch, result_ready;
   logic [15:0] sample_value = 16'h0000, lfsr = 16'h4a2d;
   logic [15:0] corners[6] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff, 16'h0001, 16'h8001};
   logic [18:0] word, exp_q[$];
   int          fail_count = 0, checked = 0;
   always #2 ref_clk = ~ref_clk;
   sarro_top i_dut (.ref_clk, .reset, .clk_en(1'b1), .convert_strobe, .sample_value,
      .echo_mode, .shift_clk, .serial_data, .echoed_shift_clock, .pos_array_ground_switch,
      .neg_array_ground_switch, .result_ready);
   sarro_host i_host (.read_en, .echo_mode, .result_ready, .serial_data, .shift_clk, .word,
      .word_done);
   function automatic logic [15:0] next_lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic convert(input logic [15:0] v, input logic m, input int gap);
      @(posedge ref_clk);
      sample_value <= v;
      echo_mode <= m;
      convert_strobe <= 1'b1;
      if (read_en) exp_q.push_back(m ? {3'h0, v} : {sarro_pkg::SELF_HEADER, v});
      repeat (10) @(posedge ref_clk);
      convert_strobe <= 1'b0;
      repeat (gap) @(posedge ref_clk);
      for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge ref_clk);
      if (exp_q.size() != 0) begin
         fail_count++;
         conclude();
      end
   endtask
   always @(word_done) begin
      logic [18:0] e;
      if (!reset) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 19'h7ffff;
         `CMP("frame", e, word)
      end
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      // Boundary codes, modes alternating
      foreach (corners[k]) convert(corners[k], k[0], 200);
      repeat (8) begin
         lfsr = next_lfsr(lfsr);
         convert(lfsr, lfsr[3], 200);
      end
      // Full-rate strobes with reads held off, then one read
      read_en = 1'b0;
      repeat (6) convert(lfsr, 1'b0, 40);
      read_en = 1'b1;
      repeat (100) @(posedge ref_clk);
      convert(16'h1234, 1'b0, 200);
      conclude();
   end
endmodule // test_sar_adc_serial_readout
`default_nettype wire

/* include/sarro_pkg.sv */
// Constants for the serial readout block of a 16-bit SAR converter.
// Assumes a 250 MHz core clock (ref_clk) and a host-made shift clock.
package sarro_pkg;
   // ----------------------------------------------------------------
   // Widths and conversion timing
   // ----------------------------------------------------------------
   localparam int          RESULT_BITS        = 16;
   localparam int          HEADER_BITS        = 3;
   localparam int          CLK_MHZ            = 250;
   localparam int          CYCLE_NS           = 4;
   // Shortest strobe period at full rate, in ns (5 MSPS)
   localparam int          MIN_PERIOD_NS      = 200;
   localparam int          MIN_PERIOD_CYCLES  = MIN_PERIOD_NS / CYCLE_NS;
   // Time from strobe to MSB available, in ns
   localparam int          READY_TIME_NS      = 100;
   localparam int          READY_CYCLES       = (READY_TIME_NS + CYCLE_NS - 1) / CYCLE_NS;
   // Self-clocked frame: leading 0, header 1 then 0
   localparam logic [2:0]  SELF_HEADER        = 3'h2;
   localparam logic [15:0] RESULT_RESET       = 16'h0000;
endpackage

/* include/sarro_sar_if.sv */
// Handshake between the readout top and its SAR sequencer.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface sarro_sar_if;
   logic        start;
   logic        comp_high;
   logic [15:0] trial;
   logic [15:0] code;
   logic        done;
   modport ctrl (output start, output comp_high, input trial, input code, input done);
   modport seq  (input start, input comp_high, output trial, output code, output done);
endinterface
`default_nettype wire

/* logic/sarro_sar_seq.sv */
// Successive-approximation sequencer: one bit per cycle, MSB first.
// Assumes comp_high answers the current trial in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module sarro_sar_seq (
   // Clock and control
   input  wire logic      ref_clk,
   input  wire logic      reset,
   input  wire logic      clk_en,
   // Sequencer side
   sarro_sar_if.seq       sar
);
   logic [15:0] bit_mask;
   logic [15:0] result;

   assign sar.trial = result | bit_mask;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bit_mask <= 16'h0000;
         result   <= 16'h0000;
         sar.done <= 1'b0;
         sar.code <= sarro_pkg::RESULT_RESET;
      end else if (clk_en) begin
         sar.done <= 1'b0;
         if (sar.start) begin
            bit_mask <= 16'h8000;
            result   <= 16'h0000;
         end else if (bit_mask != 16'h0000) begin
            bit_mask <= bit_mask >> 1;
            if (sar.comp_high) begin
               result <= sar.trial;
            end
            if (bit_mask == 16'h0001) begin
               sar.done <= 1'b1;
               // Offset binary to two's complement
               sar.code <= (sar.comp_high ? sar.trial : result) ^ 16'h8000;
            end
         end
      end
   end
endmodule // sarro_sar_seq
`default_nettype wire

/* logic/sarro_top.sv */
// Conversion timing and serial readout of a 16-bit SAR converter.
// Assumes the host strobes conversions on ref_clk and bursts shift_clk.
//
// Contract
// - A strobe rising edge after acquisition ends sampling and starts a conversion.
// - Each result belongs to the sample taken by its own strobe, with no latency.
// - Conversions keep up with strobes arriving at five million per second.
// - The MSB is offered only once the result-ready time after the strobe has passed.
// - Host shift clock edges put successive result bits on the serial output.
// - Results are 16-bit two's complement, sent MSB first.
// - Bits resolve by successive approximation from the MSB down.
// - Echoed-clock and self-clocked read modes are both supported.
// - Serial data changes on the falling edge of the shift clock.
// - Self-clocked mode sends a leading 0, header bits 1 and 0, then the result.
// - Echoed-clock mode returns a copy of the shift clock alongside the data.
`timescale 1ns/1ps
`default_nettype none
module sarro_top #(
   parameter int READY_CYCLES = sarro_pkg::READY_CYCLES
) (
   // Core clock and control
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   // Conversion strobe and sampled input model
   input  wire logic        convert_strobe,
   input  wire logic [15:0] sample_value,
   // Read mode: low selects self-clocked mode
   input  wire logic        echo_mode,
   // Link
   input  wire logic        shift_clk,
   output logic             serial_data,
   output logic             echoed_shift_clock,
   // Status
   output logic             pos_array_ground_switch,
   output logic             neg_array_ground_switch,
   output logic             result_ready
);
   typedef enum logic [1:0] {ST_ACQUIRE, ST_CONVERT, ST_WAIT} sarro_state_t;

   sarro_sar_if sar ();
   sarro_state_t state;
   logic [2:0]  strobe_sync;
   logic [1:0]  mode_sync;
   logic [31:0] sample_pipe;
   logic [15:0] held_sample;
   logic [7:0]  ready_count;
   logic        ready_now;
   logic [18:0] frame;
   logic        frame_echo;
   logic        frame_toggle;
   logic [1:0]  ack_sync;
   // Link side has no reset: its clock is stopped while reset is high
   logic        link_tog_seen = 1'b0;
   logic        link_echo;
   logic [18:0] link_shift;

   sarro_sar_seq u_seq (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .sar     (sar)
   );

   // ----------------------------------------------------------------
   // Strobe capture and conversion control
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         strobe_sync <= 3'h0;
         mode_sync   <= 2'h0;
      end else if (clk_en) begin
         strobe_sync <= {strobe_sync[1:0], convert_strobe};
         mode_sync   <= {mode_sync[0], echo_mode};
      end
   end

   // Sample bus delayed to line up with the synchronised strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sample_pipe <= 32'h00000000;
      end else if (clk_en) begin
         sample_pipe <= {sample_pipe[15:0], sample_value};
      end
   end

   assign sar.start = clk_en && state == ST_ACQUIRE && strobe_sync[1] && !strobe_sync[2];
   // Comparator model against the held sample in offset binary
   assign sar.comp_high = (held_sample ^ 16'h8000) >= sar.trial;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         held_sample <= 16'h0000;
      end else if (clk_en && sar.start) begin
         held_sample <= sample_pipe[31:16];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= ST_ACQUIRE;
      end else if (clk_en) begin
         case (state)
            ST_ACQUIRE: begin
               if (sar.start) begin
                  state <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (sar.done) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // back to acquire well inside 200 ns
               if (ready_now) begin
                  state <= ST_ACQUIRE;
               end
            end
            default: state <= ST_ACQUIRE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ready_count <= 8'h00;
      end else if (clk_en) begin
         if (sar.start) begin
            ready_count <= 8'h01;
         end else if (state != ST_ACQUIRE && !ready_now) begin
            ready_count <= ready_count + 8'h01;
         end
      end
   end

   // switches open for the whole conversion
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pos_array_ground_switch <= 1'b1;
         neg_array_ground_switch <= 1'b1;
      end else if (clk_en) begin
         if (sar.start) begin
            pos_array_ground_switch <= 1'b0;
            neg_array_ground_switch <= 1'b0;
         end else if (ready_now) begin
            pos_array_ground_switch <= 1'b1;
            neg_array_ground_switch <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         result_ready <= 1'b0;
      end else if (clk_en) begin
         if (sar.start) begin
            result_ready <= 1'b0;
         end else if (ready_now) begin
            result_ready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Frame hand-off to the link domain
   // ----------------------------------------------------------------
   // Ready decode shared by the control and frame registers
   assign ready_now = state == ST_WAIT && ready_count >= 8'(READY_CYCLES);

   // Link acknowledge, two flip-flops into ref_clk
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_sync <= 2'h0;
      end else if (clk_en) begin
         ack_sync <= {ack_sync[0], link_tog_seen};
      end
   end

   // the frame carries this conversion's own code
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frame        <= 19'h00000;
         frame_echo   <= 1'b0;
         frame_toggle <= 1'b0;
      end else if (clk_en && ready_now) begin
         // MSB first after header; 0,1,0 header
         frame      <= {sarro_pkg::SELF_HEADER, sar.code};
         frame_echo <= mode_sync[1];
         // A frame the host skipped is overwritten, never queued
         if (frame_toggle == ack_sync[1]) begin
            frame_toggle <= ~frame_toggle;
         end
      end
   end

   // ----------------------------------------------------------------
   // Link domain: shifts on the host clock
   // ----------------------------------------------------------------
   // The shift clock only runs in bursts, so a synchroniser here would not
   // advance before the first bit. The host keeps it still around the ready
   // time, the only time frame, frame_echo and frame_toggle change.

   // data changes on the falling edge; one bit per edge
   always_ff @(negedge shift_clk) begin
      if (frame_toggle != link_tog_seen) begin
         link_tog_seen <= frame_toggle;
         link_echo     <= frame_echo;
         if (frame_echo) begin
            link_shift  <= {frame[14:0], 4'h0};
            serial_data <= frame[15];
         end else begin
            link_shift  <= {frame[17:0], 1'b0};
            serial_data <= frame[18];
         end
      end else begin
         link_shift  <= {link_shift[17:0], 1'b0};
         serial_data <= link_shift[18];
      end
   end

   // echoed clock copy, held low in self-clocked mode
   always_ff @(posedge shift_clk or negedge shift_clk) begin
      echoed_shift_clock <= shift_clk & link_echo;
   end
endmodule // sarro_top
`default_nettype wire
